// File: src/alarm_sticky_aggregator.sv
/*
  Alarm status and alert aggregation with a classic Wishbone slave.
  Holds live and sticky bits for reference monitors and loops, block
  sticky bits, alert masking, and per-pin alarm outputs.
  Assumes monitor alarms and loop states come from logic on clock.
  They pass no synchroniser, so a source from another clock domain
  must be brought onto clock before it reaches these ports.
  The alert pin negates only after a hold time; poll it or use it
  as a level, never as an edge-triggered interrupt.
*/
`timescale 1ns/100ps
module alarm_sticky_aggregator #(
  parameter int NUM_REF    = 4,
  parameter int NUM_CH     = 4,
  parameter int NUM_PINS   = 4,
  parameter int NEG_CYCLES = alarm_pkg::NEG_CYCLES
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  // Wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [7:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  // Reference monitor alarms
  input  wire logic [NUM_REF-1:0]           ref_freq_alarm,
  input  wire logic [NUM_REF-1:0]           ref_los_alarm,
  input  wire logic [NUM_REF-1:0]           ref_act_alarm,
  // Loop states, channel loops then system_loop last
  input  wire logic [NUM_CH:0][2:0]         loop_state,
  input  wire logic                         analog_loop_locked,
  // Alarm pins
  output logic      [NUM_PINS-1:0]          pin_out,
  output logic      [NUM_PINS-1:0]          pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Sizes
  // Flat source vector: three bits per monitor, then two per
  // loop with the system_loop last. Block bits follow the same
  // order, one per monitor or loop.

  localparam int NLOOP = NUM_CH + 1;
  localparam int NREFA = alarm_pkg::REF_ALARMS * NUM_REF;
  localparam int NSRC  = NREFA + alarm_pkg::LOOP_ALARMS * NLOOP;
  localparam int NBLK  = NUM_REF + NLOOP;
  // Hold counter width; NEG_LAST is the count that releases
  localparam int CW    = $clog2(NEG_CYCLES + 1);
  localparam logic [CW-1:0] NEG_LAST = CW'(NEG_CYCLES - 1);

  // Module state outside the sticky detector bank; one reset branch
  // covers every flip-flop of this module, u_sticky resets its own
  typedef struct packed {
    logic                       ack;        // Bus acknowledge
    logic [31:0]                rdata;      // Read data
    logic                       gen;        // Global alarm enable
    logic                       alert_inv;  // Alert polarity
    logic [NSRC-1:0]            alert_en;   // Alert source mask
    logic [NBLK-1:0]            blk_sticky; // Block sticky bits
    logic [NUM_PINS-1:0][15:0]  pin_cfg;    // Pin configuration
    logic                       alert_act;  // Alert level after hold
    logic [CW-1:0]              neg_cnt;    // Negation hold counter
    logic [NUM_PINS-1:0]        pin_out;    // Registered pin levels
    logic [NUM_PINS-1:0]        pin_oe;     // Registered pin enables
  } state_s;

  // Present and next copies of the state
  state_s st_reg;
  state_s st_next;

  ////////////////////////////////////////////////////////////////////////
  // Byte lane merge, used by every writable register
  // Unselected lanes keep the old value, so a clear
  // with no lanes selected clears nothing

  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Live alarm vector

  logic [NSRC-1:0] live;        // Present alarm conditions
  logic [NSRC-1:0] sticky;      // Individual sticky bits
  logic [NSRC-1:0] sticky_clr;  // Clear strobes for sticky bits
  logic [NBLK-1:0] blk_any;     // Block has a sticky bit set
  logic [NBLK-1:0] blk_en;      // Block has an alert-enabled source

  // Live bits are wiring from the inputs, so a read returns
  // the level of the cycle in which the access is taken.
  // Monitor alarms pass straight through; loop alarms are
  // decoded from each loop's state code.
  genvar g;
  generate
    // Each monitor feeds three alarm types
    for (g = 0; g < NUM_REF; g++)
    begin : g_ref
      assign live[3*g]     = ref_freq_alarm[g];
      assign live[3*g + 1] = ref_los_alarm[g];
      assign live[3*g + 2] = ref_act_alarm[g];
      assign blk_any[g] = |sticky[3*g +: 3];
      assign blk_en[g]  = |st_reg.alert_en[3*g +: 3];
    end
    // Each loop feeds holdover and locked
    // Losing the analog lock drops locked on every loop
    // at once, since locked needs both loops
    for (g = 0; g < NLOOP; g++)
    begin : g_loop
      localparam int B = NREFA + 2*g;
      assign live[B] =
        (loop_state[g] == alarm_pkg::LS_HOLDOVER);
      assign live[B + 1] =
        (loop_state[g] == alarm_pkg::LS_LOCKED) && analog_loop_locked;
      assign blk_any[NUM_REF + g] = |sticky[B +: 2];
      assign blk_en[NUM_REF + g]  = |st_reg.alert_en[B +: 2];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Sticky change detectors
  // Both edges of a live bit set its sticky bit. The global
  // enable blocks new events only; set bits are kept, so a
  // service routine can pause alarms without losing a cause.

  alarm_edge_sticky #(
    .W (NSRC)
  ) u_sticky (
    .clock   (clock),
    .sys_rst (sys_rst),
    .live    (live),
    .gen     (st_reg.gen),
    .clr     (sticky_clr),
    .sticky  (sticky)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  // A request is taken only while no acknowledge stands, so
  // a strobe held over the acknowledge edge is not answered
  // twice. Mapped or not, each access is answered next cycle.

  logic        acc;      // New access this cycle
  logic        wr;       // New write this cycle
  logic [31:0] wmask;    // Written bits after byte lanes
  logic        pin_hit;  // Address falls in the pin table
  logic [5:0]  pin_idx;  // Word index inside the pin table

  // Decode terms, from the present bus inputs and the standing acknowledge
  assign acc     = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign wr      = acc && wb_we_i;
  assign wmask   = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign pin_idx = wb_adr_i[7:2] - alarm_pkg::OFS_PIN_BASE[7:2];
  // Words past the last pin read zero and ignore writes
  assign pin_hit = (wb_adr_i >= alarm_pkg::OFS_PIN_BASE) &&
                   (int'(pin_idx) < NUM_PINS);

  // Write-one-to-clear strobes for individual stickies
  // A clear meeting a fresh edge in one cycle loses to it,
  // so a late clear never drops an event
  always_comb
  begin
    sticky_clr = '0;
    if (wr && wb_adr_i[7:2] == alarm_pkg::OFS_STICKY[7:2])
      sticky_clr = wmask[NSRC-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Alert source and pin levels

  logic                alert_src;  // Raw OR of enabled sticky state
  logic [NUM_PINS-1:0] pin_level;  // Pin level from the mux
  logic [NUM_PINS-1:0] pin_drive;  // Pin enable from the mux

  // Only sticky state reaches the alert, never live bits
  // A block bit counts only if its block has an enabled
  // source; masked blocks would otherwise raise the pin
  assign alert_src = |(sticky & st_reg.alert_en)
                   | |(st_reg.blk_sticky & blk_en);

  // Pin levels are formed here and registered below, so a
  // pin follows the alarm state one cycle later
  alarm_pin_mux #(
    .NPIN  (NUM_PINS),
    .NSRC  (NSRC),
    .NREFA (NREFA)
  ) u_pins (
    .live      (live),
    .sticky    (sticky),
    .alert     (st_reg.alert_act),
    .alert_inv (st_reg.alert_inv),
    .cfg       (st_reg.pin_cfg),
    .level     (pin_level),
    .drive     (pin_drive)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state
  // One process forms every next value: bus answer, writes,
  // read data, block stickies, alert hold and pin registers.
  // Defaults keep the state, so a branch names only what moves.

  always_comb
  begin
    logic [31:0] m;
    logic [31:0] rd;
    m  = 32'h0000_0000;
    rd = 32'h0000_0000;
    st_next     = st_reg;
    // One-cycle acknowledge per access
    // The standing acknowledge blocks a second take
    st_next.ack = acc;

    // Block sticky: any set individual sticky sets it again while gen is on
    // Clearing a block while a member is set and gen is on leaves it set
    st_next.blk_sticky = st_reg.blk_sticky |
                         (blk_any & {NBLK{st_reg.gen}});

    // Register writes
    // Read-only and unmapped words fall to the default
    // branch and change nothing; they are still answered
    if (wr)
    begin
      case (wb_adr_i[7:2])
        alarm_pkg::OFS_CTRL[7:2]:
        begin
          m = merge({30'h0, st_reg.alert_inv, st_reg.gen}, wb_dat_i, wb_sel_i);
          st_next.gen       = m[alarm_pkg::CTRL_GEN_BIT];
          st_next.alert_inv = m[alarm_pkg::CTRL_AINV_BIT];
        end
        alarm_pkg::OFS_ALERT_EN[7:2]:
        begin
          m = merge(32'(st_reg.alert_en), wb_dat_i, wb_sel_i);
          st_next.alert_en = m[NSRC-1:0];
        end
        alarm_pkg::OFS_BLK_STICKY[7:2]:
        begin
          // Clear first, then a still-set member sets it again if gen is on
          st_next.blk_sticky = (st_reg.blk_sticky & ~wmask[NBLK-1:0])
                             | (blk_any & {NBLK{st_reg.gen}});
        end
        default:
        begin
          if (pin_hit)
          begin
            m = merge(32'(st_reg.pin_cfg[pin_idx]), wb_dat_i, wb_sel_i);
            st_next.pin_cfg[pin_idx] = m[15:0];
          end
        end
      endcase
    end

    // Read data, sampled in the access cycle
    // Live and sticky words show the state of the taking edge
    if (acc && !wb_we_i)
    begin
      case (wb_adr_i[7:2])
        alarm_pkg::OFS_CTRL[7:2]:
          rd = {30'h0, st_reg.alert_inv, st_reg.gen};
        alarm_pkg::OFS_LIVE[7:2]:
          rd = 32'(live);
        alarm_pkg::OFS_STICKY[7:2]:
          rd = 32'(sticky);
        alarm_pkg::OFS_ALERT_EN[7:2]:
          rd = 32'(st_reg.alert_en);
        alarm_pkg::OFS_BLK_STICKY[7:2]:
          rd = 32'(st_reg.blk_sticky);
        alarm_pkg::OFS_LOOP_STATE[7:2]:
          rd = 32'(loop_state);
        alarm_pkg::OFS_STATUS[7:2]:
          rd = {30'h0, alert_src, st_reg.alert_act};
        default:
        begin
          if (pin_hit)
            rd = 32'(st_reg.pin_cfg[pin_idx]);
          else
            rd = 32'h0000_0000;
        end
      endcase
    end
    // Read data is zero outside an acknowledged read
    st_next.rdata = rd;

    // Alert asserts at once, negates only after a quiet hold time;
    // this keeps a host from seeing a burst of edges while it clears
    // The counter parks at its last value until the source rises
    if (alert_src)
    begin
      st_next.alert_act = 1'b1;
      st_next.neg_cnt   = '0;
    end
    else if (st_reg.alert_act)
    begin
      if (st_reg.neg_cnt == NEG_LAST)
        st_next.alert_act = 1'b0;
      else
        st_next.neg_cnt = st_reg.neg_cnt + CW'(1);
    end

    // Registered pin outputs
    // Mode off leaves the pin undriven and its level low
    st_next.pin_out = pin_level;
    st_next.pin_oe  = pin_drive;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  // Reset clears every field, then the control fields take
  // their package reset values; all of them are constants.

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg           <= '0;
      st_reg.gen       <= alarm_pkg::CTRL_GEN_RST;
      st_reg.alert_inv <= alarm_pkg::CTRL_AINV_RST;
      st_reg.pin_cfg   <= {NUM_PINS{alarm_pkg::PIN_CFG_RST}};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  // Nothing combinational reaches a pin, so none can glitch

  assign wb_dat_o = st_reg.rdata;
  assign wb_ack_o = st_reg.ack;
  assign pin_out  = st_reg.pin_out;
  assign pin_oe   = st_reg.pin_oe;

endmodule // alarm_sticky_aggregator

// File: src/alarm_pkg.sv
/*
  Constants shared by the alarm status and alert logic: register offsets,
  field positions, reset values, pin modes, loop state codes and timing.
  Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave port.
*/
// Operation
// - Live bit shows present alarm when read
// - Sticky sets on change, holds until cleared
// - Both rising and falling edges set sticky
// - Single-alarm pin shows live or sticky level; code offers sticky for loop alarms only
// - Per-pin invert of individual alarm output
// - Alert built from sticky bits only
// - Alert is OR of enabled sticky bits
// - Any pin may be chosen as alert
// - Per-source enables feed the alert
// - Alert pin polarity can be inverted
// - Monitors, channel loops, system loop are sources
// - Holdover live follows loop holdover state
// - Locked needs channel loop and analog loop locked
// - Loop stickies on state moves; state readable
// - Every alarm bit has its own clear
// - Block sticky also holds alert until cleared
// - Alert may negate up to 200 us late
// - Global enable suppresses new alarms
package alarm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_LIVE      = 8'h04;
  localparam logic [7:0] OFS_STICKY    = 8'h08;
  localparam logic [7:0] OFS_ALERT_EN  = 8'h0C;
  localparam logic [7:0] OFS_BLK_STICKY = 8'h10;
  localparam logic [7:0] OFS_LOOP_STATE = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_PIN_BASE  = 8'h20;

  // Control register fields
  localparam int CTRL_GEN_BIT   = 0;
  localparam int CTRL_AINV_BIT  = 1;
  localparam logic CTRL_GEN_RST  = 1'b0;
  localparam logic CTRL_AINV_RST = 1'b0;

  // Pin configuration fields
  localparam int PIN_MODE_LSB  = 0;
  localparam int PIN_STICKY_BIT = 2;
  localparam int PIN_INV_BIT   = 3;
  localparam int PIN_SRC_LSB   = 8;
  localparam int PIN_SRC_W     = 5;
  localparam int PIN_CFG_W     = 16;
  localparam logic [15:0] PIN_CFG_RST = 16'h0000;

  // Alarms per block
  localparam int REF_ALARMS  = 3;
  localparam int LOOP_ALARMS = 2;
  localparam int LOOP_ST_W   = 3;

  // Pin modes
  typedef enum logic [1:0] {
    PIN_OFF    = 2'b00,
    PIN_SINGLE = 2'b01,
    PIN_ALERT  = 2'b10
  } pin_mode_e;

  // Loop state machine codes
  typedef enum logic [2:0] {
    LS_FREERUN  = 3'b000,
    LS_ACQUIRE  = 3'b001,
    LS_LOCKED   = 3'b010,
    LS_HOLDOVER = 3'b011
  } loop_state_e;

  // Alert negation hold time
  localparam int CLK_PERIOD_NS = 10;
  localparam int NEG_TIME_NS   = 200000;
  localparam int NEG_CYCLES    = NEG_TIME_NS / CLK_PERIOD_NS;

endpackage

// File: src/alarm_edge_sticky.sv
/*
  Bank of sticky change detectors, one per alarm source.
  Assumes live inputs are synchronous to clock.
*/
`timescale 1ns/100ps
module alarm_edge_sticky #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Alarm levels and controls
  input  wire logic [W-1:0] live,
  input  wire logic         gen,
  input  wire logic [W-1:0] clr,
  // Sticky result
  output logic      [W-1:0] sticky
);

  typedef struct packed {
    logic [W-1:0] prev;   // Live level one cycle ago
    logic [W-1:0] sticky; // Latched change flags
  } state_s;

  state_s st_reg;
  state_s st_next;

  // Any edge sets; global enable blocks new events; set beats clear
  always_comb
  begin
    st_next        = st_reg;
    st_next.prev   = live;
    st_next.sticky = (st_reg.sticky & ~clr)
                   | ({W{gen}} & (live ^ st_reg.prev));
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign sticky = st_reg.sticky;

endmodule // alarm_edge_sticky

// File: src/alarm_pin_mux.sv
/*
  Per-pin selection of alarm level: one live or sticky alarm, or the alert.
  Combinational; the caller registers the result.
*/
`timescale 1ns/100ps
module alarm_pin_mux #(
  parameter int NPIN = 4,
  parameter int NSRC = 22,
  parameter int NREFA = 12
) (
  // Alarm vectors
  input  wire logic [NSRC-1:0]           live,
  input  wire logic [NSRC-1:0]           sticky,
  input  wire logic                      alert,
  input  wire logic                      alert_inv,
  // Pin configuration
  input  wire logic [NPIN-1:0][15:0]     cfg,
  // Pin levels
  output logic      [NPIN-1:0]           level,
  output logic      [NPIN-1:0]           drive
);

  genvar p;
  generate
    for (p = 0; p < NPIN; p++)
    begin : g_pin
      logic [alarm_pkg::PIN_SRC_W-1:0] src;
      logic [1:0]                      mode;
      logic                            bit_v;
      assign src  = cfg[p][alarm_pkg::PIN_SRC_LSB +: alarm_pkg::PIN_SRC_W];
      assign mode = cfg[p][alarm_pkg::PIN_MODE_LSB +: 2];
      // Monitor alarms are live only; loop alarms may show sticky
      always_comb
      begin
        bit_v = 1'b0;
        if (int'(src) < NSRC)
        begin
          if (cfg[p][alarm_pkg::PIN_STICKY_BIT] && int'(src) >= NREFA)
            bit_v = sticky[src];
          else
            bit_v = live[src];
        end
      end
      // Mode select and polarity
      always_comb
      begin
        case (mode)
          alarm_pkg::PIN_SINGLE:
          begin
            level[p] = bit_v ^ cfg[p][alarm_pkg::PIN_INV_BIT];
            drive[p] = 1'b1;
          end
          alarm_pkg::PIN_ALERT:
          begin
            level[p] = alert ^ alert_inv;
            drive[p] = 1'b1;
          end
          default:
          begin
            level[p] = 1'b0;
            drive[p] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

endmodule // alarm_pin_mux

// File: bench/alarm_sticky_aggregator_properties.sv
/*
  Port checker for the alarm aggregator: bus handshake and live readback.
  Assumes one clock domain and aligned register addresses.
*/
`timescale 1ns/100ps
module alarm_sticky_aggregator_properties #(
  parameter int NUM_REF = 4,
  parameter int NUM_CH  = 4
) (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 sys_rst,
  // Bus
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  // Alarm inputs
  input wire logic [NUM_REF-1:0]   ref_freq_alarm,
  input wire logic [NUM_CH:0][2:0] loop_state,
  input wire logic                 analog_loop_locked
);
  // A request is taken only while no answer stands
  logic take;
  // Read request of any address
  logic rd;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd = take && !wb_we_i;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  chk_ack_taken: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  chk_live_freq: assert property (rd && wb_adr_i == alarm_pkg::OFS_LIVE
    |=> wb_dat_o[0] == $past(ref_freq_alarm[0])) else $error("live freq bit wrong");
  chk_holdover_live: assert property (rd && wb_adr_i == alarm_pkg::OFS_LIVE
    |=> wb_dat_o[12] == ($past(loop_state[0]) == alarm_pkg::LS_HOLDOVER))
    else $error("holdover bit wrong");
  chk_locked_live: assert property (rd && wb_adr_i == alarm_pkg::OFS_LIVE
    |=> wb_dat_o[13] == ($past(loop_state[0]) == alarm_pkg::LS_LOCKED
                         && $past(analog_loop_locked)))
    else $error("locked bit wrong");
  chk_state_read: assert property (rd && wb_adr_i == alarm_pkg::OFS_LOOP_STATE
    |=> wb_dat_o[2:0] == $past(loop_state[0])) else $error("loop state wrong");
  chk_unmapped_zero: assert property (rd && wb_adr_i == 8'h1C
    |=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
endmodule // alarm_sticky_aggregator_properties

bind alarm_sticky_aggregator alarm_sticky_aggregator_properties #(
  .NUM_REF(NUM_REF),
  .NUM_CH(NUM_CH)
) chk (
  .clock(clock),
  .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .ref_freq_alarm(ref_freq_alarm),
  .loop_state(loop_state),
  .analog_loop_locked(analog_loop_locked)
);

// File: bench/alarm_host_model.sv
/*
  Host processor model: classic Wishbone master that polls and clears.
  Assumes the slave answers within a few cycles; a stall ends in a timeout.
*/
`timescale 1ns/100ps
module alarm_host_model (
  // Clock
  input  wire logic        clock,
  // Master outputs
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat_w,
  // Slave answer
  input  wire logic        ack,
  input  wire logic [31:0] dat_r
);
  // Idle bus at time zero
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
  end
  // One access; the alert pin is never used as an edge interrupt, only polled
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output bit to);
    begin
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat_w <= d;
      to = 1'b1;
      q = 32'h0000_0000;
      for (int i = 0; i < 20; i++)
      begin
        @(posedge clock);
        if (ack === 1'b1)
        begin
          q = dat_r;
          to = 1'b0;
          break;
        end
      end
      // Release; stale data is not left on the lines
      cyc <= 1'b0;
      stb <= 1'b0;
      dat_w <= ~d;
    end
  endtask
endmodule // alarm_host_model

// File: bench/test_alarm_sticky_aggregator.sv
/*
  Testbench for the alarm aggregator: register polling, stickies, alert pin.
  Assumes the host model for bus cycles and a short alert hold of 8 cycles.
*/
`timescale 1ns/100ps
module test_alarm_sticky_aggregator;
  logic             clock = 1'b0;
  logic             sys_rst = 1'b1;
  logic             cyc, stb, we, ack;
  logic [7:0]       adr;
  logic [3:0]       sel;
  logic [31:0]      dat_w, dat_r, q;
  logic [3:0]       freq, los, act, pin_out, pin_oe;
  logic [4:0][2:0]  lst;
  logic             alock;
  bit               to;
  int               n_errors = 0;
  int               checked = 0;
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  alarm_sticky_aggregator #(.NEG_CYCLES(8)) uut (
    .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .ref_freq_alarm(freq),
    .ref_los_alarm(los), .ref_act_alarm(act), .loop_state(lst),
    .analog_loop_locked(alock), .pin_out(pin_out), .pin_oe(pin_oe));
  alarm_host_model host (
    .clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dat_w), .ack(ack), .dat_r(dat_r));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bus helpers; a stalled slave ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    host.access(1'b1, a, d, s, q, to);
    if (to)
    begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.access(1'b0, a, 32'h0000_0000, 4'hF, q, to);
    if (to)
    begin
      n_errors++;
      tally_and_finish;
    end
    else
      check(q, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {freq, los, act, lst, alock} = '0;
    tick(4);
    sys_rst <= 1'b0;
    rd(alarm_pkg::OFS_CTRL, 32'h0000_0000);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000);
    // Alarm while globally disabled leaves no sticky
    freq[1] <= 1'b1;
    tick(3);
    rd(alarm_pkg::OFS_LIVE, 32'h0000_0008);
    rd(alarm_pkg::OFS_STICKY, 32'h0000_0000);
    freq[1] <= 1'b0;
    wr(alarm_pkg::OFS_CTRL, 32'h0000_0001);
    wr(alarm_pkg::OFS_ALERT_EN, 32'h0000_0001);
    wr(alarm_pkg::OFS_PIN_BASE, 32'h0000_0002);
    wr(alarm_pkg::OFS_PIN_BASE + 8'h04, 32'h0000_0409);
    tick(3);
    check({28'h0, pin_oe}, 32'h0000_0003);
    check({31'h0, pin_out[1]}, 32'h0000_0001);
    // Loss on ref 1: inverted live pin, not enabled to alert
    los[1] <= 1'b1;
    tick(4);
    check({31'h0, pin_out[1]}, 32'h0000_0000);
    check({31'h0, pin_out[0]}, 32'h0000_0000);
    rd(alarm_pkg::OFS_STICKY, 32'h0000_0010);
    wr(alarm_pkg::OFS_STICKY, 32'h0000_0010);
    rd(alarm_pkg::OFS_STICKY, 32'h0000_0000);
    los[1] <= 1'b0;
    tick(3);
    rd(alarm_pkg::OFS_STICKY, 32'h0000_0010);
    rd(alarm_pkg::OFS_BLK_STICKY, 32'h0000_0002);
    wr(alarm_pkg::OFS_STICKY, 32'h0000_0010);
    wr(alarm_pkg::OFS_BLK_STICKY, 32'h0000_0002);
    // Enabled source drives the alert; sticky keeps it after live drops
    freq[0] <= 1'b1;
    tick(5);
    check({31'h0, pin_out[0]}, 32'h0000_0001);
    freq[0] <= 1'b0;
    tick(5);
    check({31'h0, pin_out[0]}, 32'h0000_0001);
    wr(alarm_pkg::OFS_STICKY, 32'hFFFF_FFFF, 4'h0);
    rd(alarm_pkg::OFS_STICKY, 32'h0000_0001);
    wr(alarm_pkg::OFS_STICKY, 32'h0000_0001);
    tick(14);
    check({31'h0, pin_out[0]}, 32'h0000_0001);
    wr(alarm_pkg::OFS_BLK_STICKY, 32'h0000_0001);
    tick(3);
    check({31'h0, pin_out[0]}, 32'h0000_0001);
    tick(10);
    check({31'h0, pin_out[0]}, 32'h0000_0000);
    wr(alarm_pkg::OFS_CTRL, 32'h0000_0003);
    tick(3);
    check({31'h0, pin_out[0]}, 32'h0000_0001);
    // Loop 0: holdover, then locked with the analog loop
    lst[0] <= 3'h3;
    tick(2);
    rd(alarm_pkg::OFS_LIVE, 32'h0000_1000);
    lst[0] <= 3'h2;
    alock <= 1'b1;
    tick(2);
    rd(alarm_pkg::OFS_LIVE, 32'h0000_2000);
    rd(alarm_pkg::OFS_LOOP_STATE, 32'h0000_0002);
    alock <= 1'b0;
    tick(2);
    rd(alarm_pkg::OFS_LIVE, 32'h0000_0000);
    rd(alarm_pkg::OFS_STICKY, 32'h0000_3000);
    // Block clear while members are set: the set wins
    wr(alarm_pkg::OFS_BLK_STICKY, 32'h0000_0010);
    rd(alarm_pkg::OFS_BLK_STICKY, 32'h0000_0010);
    wr(alarm_pkg::OFS_PIN_BASE + 8'h04, 32'h0000_0D0D);
    tick(3);
    check({31'h0, pin_out[1]}, 32'h0000_0000);
    tally_and_finish;
  end
endmodule // test_alarm_sticky_aggregator
